// File: hdl/dpm_cyc_if.sv
`default_nettype none
interface dpm_cyc_if;
	logic                  req;
	dpm_pkg::dpm_kind_e    kind;
	logic [dpm_pkg::AW-1:0] addr;
	logic [dpm_pkg::DW-1:0] wdata;
	logic                  done;
	logic                  blocked;
	logic [dpm_pkg::DW-1:0] rdata;

	modport ctl (output req, kind, addr, wdata, input done, blocked, rdata);
	modport seq (input req, kind, addr, wdata, output done, blocked, rdata);
endinterface
`default_nettype wire

// File: hdl/dpm_host.sv
// Behaviour
// - without interrupts, flags are ignored and mailboxes are plain memory.
// - depth-stacked busy signals are ANDed together.
// - one master per width-expanded array; slaves use its busy.
// - hold address and enable until busy settles, then pulse write.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
module dpm_host
#(
	parameter bit PORT_IS_LEFT = 1'b1
)
(
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   rst_i,
	// software register port
	input  wire logic [2:0]             reg_addr_i,
	input  wire logic [dpm_pkg::DW-1:0] reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [dpm_pkg::DW-1:0] reg_rdata_o,
	// device port pins
	output logic      [dpm_pkg::AW-1:0] addr_o,
	output logic                        ce_n_o,
	output logic                        token_space_select_n_o,
	output logic                        rw_n_o,
	output logic                        oe_n_o,
	output logic                        data_oe_o,
	output logic      [dpm_pkg::DW-1:0] data_o,
	input  wire logic [dpm_pkg::DW-1:0] data_i,
	input  wire logic                   busy_n_i,
	input  wire logic                   mailbox_flag_n_i
);
	localparam logic [dpm_pkg::AW-1:0] OWN_MBOX  =
		PORT_IS_LEFT ? dpm_pkg::MBOX_LEFT_ADDR : dpm_pkg::MBOX_RIGHT_ADDR;
	localparam logic [dpm_pkg::AW-1:0] PEER_MBOX =
		PORT_IS_LEFT ? dpm_pkg::MBOX_RIGHT_ADDR : dpm_pkg::MBOX_LEFT_ADDR;

	dpm_cyc_if cyc ();

	logic                   mbox_en_r, mbox_en_nxt;
	logic [dpm_pkg::AW-1:0] addr_r, addr_nxt;
	logic [dpm_pkg::DW-1:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, rd_nxt;
	logic                   active_r, active_nxt, done_r, done_nxt, blk_r, blk_nxt;
	logic                   req_r, req_nxt;
	dpm_pkg::dpm_kind_e     kind_r, kind_nxt;
	logic [dpm_pkg::AW-1:0] caddr_r, caddr_nxt;
	logic [dpm_pkg::DW-1:0] cwdata_r, cwdata_nxt;
	logic                   cmd_take;

	assign cyc.req   = req_r;
	assign cyc.kind  = kind_r;
	assign cyc.addr  = caddr_r;
	assign cyc.wdata = cwdata_r;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	function automatic dpm_pkg::dpm_kind_e cmd_kind(input logic [2:0] c);
		if (c == dpm_pkg::CMD_MEM_WR || c == dpm_pkg::CMD_NOTIFY)
			return dpm_pkg::K_MEM_WR;
		else if (c == dpm_pkg::CMD_SEM_RD)
			return dpm_pkg::K_SEM_RD;
		else if (c == dpm_pkg::CMD_SEM_WR)
			return dpm_pkg::K_SEM_WR;
		else
			return dpm_pkg::K_MEM_RD;
	endfunction

	function automatic logic [dpm_pkg::AW-1:0] cmd_addr(input logic [2:0] c,
		input logic [dpm_pkg::AW-1:0] a);
		if (c == dpm_pkg::CMD_NOTIFY)
			return PEER_MBOX;
		else if (c == dpm_pkg::CMD_ACK)
			return OWN_MBOX;
		else if (c == dpm_pkg::CMD_SEM_RD || c == dpm_pkg::CMD_SEM_WR)
			return a & dpm_pkg::SEM_ADDR_MASK;
		else
			return a;
	endfunction

	// a new command while one runs is dropped; software polls the active bit
	assign cmd_take = reg_wr_i && reg_addr_i == dpm_pkg::REG_CMD && !active_r;

	// ----------------------------------------------------------------
	// register file and command launch
	// ----------------------------------------------------------------
	always_comb
	begin
		mbox_en_nxt = mbox_en_r;
		addr_nxt    = addr_r;
		wdata_nxt   = wdata_r;
		rdata_nxt   = rdata_r;
		active_nxt  = active_r;
		done_nxt    = done_r;
		blk_nxt     = blk_r;
		req_nxt     = 1'b0;
		kind_nxt    = kind_r;
		caddr_nxt   = caddr_r;
		cwdata_nxt  = cwdata_r;
		rd_nxt      = dpm_pkg::ZERO_W;
		if (reg_wr_i)
		begin
			if (reg_addr_i == dpm_pkg::REG_CTRL)
				mbox_en_nxt = reg_wdata_i[dpm_pkg::CTRL_MBOX_EN];
			else if (reg_addr_i == dpm_pkg::REG_ADDR)
				addr_nxt = reg_wdata_i[dpm_pkg::AW-1:0];
			else if (reg_addr_i == dpm_pkg::REG_WDATA)
				wdata_nxt = reg_wdata_i;
			else if (reg_addr_i == dpm_pkg::REG_STATUS)
			begin
				done_nxt = done_r && !reg_wdata_i[dpm_pkg::ST_DONE];
				blk_nxt  = blk_r && !reg_wdata_i[dpm_pkg::ST_BLOCKED];
			end
		end
		if (cmd_take)
		begin
			req_nxt    = 1'b1;
			active_nxt = 1'b1;
			kind_nxt   = cmd_kind(reg_wdata_i[2:0]);
			caddr_nxt  = cmd_addr(reg_wdata_i[2:0], addr_r);
			cwdata_nxt = wdata_r;
		end
		// completion sets after the clear so a same-cycle event is kept
		if (cyc.done)
		begin
			active_nxt = 1'b0;
			done_nxt   = 1'b1;
			rdata_nxt  = cyc.rdata;
		end
		if (cyc.blocked)
			blk_nxt = 1'b1;
		if (reg_rd_i)
		begin
			if (reg_addr_i == dpm_pkg::REG_CTRL)
				rd_nxt[dpm_pkg::CTRL_MBOX_EN] = mbox_en_r;
			else if (reg_addr_i == dpm_pkg::REG_ADDR)
				rd_nxt[dpm_pkg::AW-1:0] = addr_r;
			else if (reg_addr_i == dpm_pkg::REG_WDATA)
				rd_nxt = wdata_r;
			else if (reg_addr_i == dpm_pkg::REG_RDATA)
				rd_nxt = rdata_r;
			else if (reg_addr_i == dpm_pkg::REG_STATUS)
			begin
				rd_nxt[dpm_pkg::ST_ACTIVE]  = active_r;
				rd_nxt[dpm_pkg::ST_DONE]    = done_r;
				rd_nxt[dpm_pkg::ST_BLOCKED] = blk_r;
				rd_nxt[dpm_pkg::ST_MBOX]    = mbox_en_r && !mailbox_flag_n_i;
			end
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			mbox_en_r   <= 1'b0;
			addr_r      <= 15'h0000;
			wdata_r     <= 16'h0000;
			rdata_r     <= 16'h0000;
			active_r    <= 1'b0;
			done_r      <= 1'b0;
			blk_r       <= 1'b0;
			req_r       <= 1'b0;
			kind_r      <= dpm_pkg::K_MEM_RD;
			caddr_r     <= 15'h0000;
			cwdata_r    <= 16'h0000;
			reg_rdata_o <= 16'h0000;
		end
		else
		begin
			mbox_en_r   <= mbox_en_nxt;
			addr_r      <= addr_nxt;
			wdata_r     <= wdata_nxt;
			rdata_r     <= rdata_nxt;
			active_r    <= active_nxt;
			done_r      <= done_nxt;
			blk_r       <= blk_nxt;
			req_r       <= req_nxt;
			kind_r      <= kind_nxt;
			caddr_r     <= caddr_nxt;
			cwdata_r    <= cwdata_nxt;
			reg_rdata_o <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// pin sequencer
	// ----------------------------------------------------------------
	dpm_pin_seq u_seq
	(
		.clock_i                (clock_i),
		.rst_i                  (rst_i),
		.cyc                    (cyc.seq),
		.addr_o                 (addr_o),
		.ce_n_o                 (ce_n_o),
		.token_space_select_n_o (token_space_select_n_o),
		.rw_n_o                 (rw_n_o),
		.oe_n_o                 (oe_n_o),
		.data_oe_o              (data_oe_o),
		.data_o                 (data_o),
		.data_i                 (data_i),
		.busy_n_i               (busy_n_i)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_notify_peer_addr: assert property (@(posedge clock_i) disable iff (rst_i)
		cmd_take && reg_wdata_i[2:0] == dpm_pkg::CMD_NOTIFY |=> caddr_r == PEER_MBOX
			&& kind_r == dpm_pkg::K_MEM_WR)
		else $error("notify not aimed at peer mailbox");
	a_ack_own_read: assert property (@(posedge clock_i) disable iff (rst_i)
		cmd_take && reg_wdata_i[2:0] == dpm_pkg::CMD_ACK |=> caddr_r == OWN_MBOX
			&& kind_r == dpm_pkg::K_MEM_RD)
		else $error("acknowledge not a read of own mailbox");
	a_mbox_masked: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == dpm_pkg::REG_STATUS && !mbox_en_r
			|=> !reg_rdata_o[dpm_pkg::ST_MBOX])
		else $error("mailbox flag shown while disabled");
	a_cmd_completes: assert property (@(posedge clock_i) disable iff (rst_i)
		cmd_take |-> ##[4:12] done_r)
		else $error("command did not complete in time");
endmodule
`default_nettype wire

// File: hdl/dpm_pin_seq.sv
`default_nettype none
module dpm_pin_seq
(
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	// request side
	dpm_cyc_if.seq                 cyc,
	// device port pins
	output logic [dpm_pkg::AW-1:0] addr_o,
	output logic                   ce_n_o,
	output logic                   token_space_select_n_o,
	output logic                   rw_n_o,
	output logic                   oe_n_o,
	output logic                   data_oe_o,
	output logic [dpm_pkg::DW-1:0] data_o,
	input  wire logic [dpm_pkg::DW-1:0] data_i,
	input  wire logic              busy_n_i
);
	dpm_pkg::dpm_state_e    st_r, st_nxt;
	dpm_pkg::dpm_kind_e     kind_r, kind_nxt;
	logic [2:0]             cnt_r, cnt_nxt;
	logic [dpm_pkg::AW-1:0] addr_nxt;
	logic [dpm_pkg::DW-1:0] data_nxt, rdata_r, rdata_nxt;
	logic ce_n_nxt, sem_n_nxt, rw_n_nxt, oe_n_nxt, doe_nxt;
	logic done_r, done_nxt, blk_r, blk_nxt;

	assign cyc.done    = done_r;
	assign cyc.blocked = blk_r;
	assign cyc.rdata   = rdata_r;

	// ----------------------------------------------------------------
	// pin cycle sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt    = st_r;
		kind_nxt  = kind_r;
		cnt_nxt   = cnt_r;
		addr_nxt  = addr_o;
		data_nxt  = data_o;
		rdata_nxt = rdata_r;
		ce_n_nxt  = ce_n_o;
		sem_n_nxt = token_space_select_n_o;
		rw_n_nxt  = rw_n_o;
		oe_n_nxt  = oe_n_o;
		doe_nxt   = data_oe_o;
		done_nxt  = 1'b0;
		blk_nxt   = 1'b0;
		case (st_r)
			dpm_pkg::S_IDLE:
			begin
				if (cyc.req)
				begin
					kind_nxt  = cyc.kind;
					addr_nxt  = cyc.addr;
					data_nxt  = cyc.wdata;
					ce_n_nxt  = !(cyc.kind == dpm_pkg::K_MEM_RD || cyc.kind == dpm_pkg::K_MEM_WR);
					sem_n_nxt = !ce_n_nxt;
					cnt_nxt   = dpm_pkg::SETTLE_CYC;
					st_nxt    = dpm_pkg::S_SETUP;
				end
			end
			dpm_pkg::S_SETUP:
			begin
				// address and enable stand until the arbiter's busy has settled
				if (cnt_r != dpm_pkg::CNT_ONE)
					cnt_nxt = cnt_r - dpm_pkg::CNT_ONE;
				// busy_n_i is the one master's busy, already ANDed across stacked banks
				else if (kind_r == dpm_pkg::K_MEM_WR && !busy_n_i)
				begin
					// no write pulse at all: the device would gate it anyway
					blk_nxt  = 1'b1;
					ce_n_nxt = 1'b1;
					st_nxt   = dpm_pkg::S_RECOVER;
				end
				else
				begin
					rw_n_nxt = !(kind_r == dpm_pkg::K_MEM_WR || kind_r == dpm_pkg::K_SEM_WR);
					oe_n_nxt = !rw_n_nxt;
					doe_nxt  = !rw_n_nxt;
					cnt_nxt  = dpm_pkg::STROBE_CYC;
					st_nxt   = dpm_pkg::S_STROBE;
				end
			end
			dpm_pkg::S_STROBE:
			begin
				if (cnt_r != dpm_pkg::CNT_ONE)
					cnt_nxt = cnt_r - dpm_pkg::CNT_ONE;
				else
				begin
					if (!oe_n_o)
						rdata_nxt = data_i;
					// both selects return high so a later token read relatches
					ce_n_nxt  = 1'b1;
					sem_n_nxt = 1'b1;
					rw_n_nxt  = 1'b1;
					oe_n_nxt  = 1'b1;
					st_nxt    = dpm_pkg::S_RECOVER;
				end
			end
			default:
			begin
				doe_nxt  = 1'b0;
				done_nxt = 1'b1;
				st_nxt   = dpm_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			st_r                   <= dpm_pkg::S_IDLE;
			kind_r                 <= dpm_pkg::K_MEM_RD;
			cnt_r                  <= 3'h0;
			addr_o                 <= 15'h0000;
			data_o                 <= 16'h0000;
			rdata_r                <= 16'h0000;
			ce_n_o                 <= 1'b1;
			token_space_select_n_o <= 1'b1;
			rw_n_o                 <= 1'b1;
			oe_n_o                 <= 1'b1;
			data_oe_o              <= 1'b0;
			done_r                 <= 1'b0;
			blk_r                  <= 1'b0;
		end
		else
		begin
			st_r                   <= st_nxt;
			kind_r                 <= kind_nxt;
			cnt_r                  <= cnt_nxt;
			addr_o                 <= addr_nxt;
			data_o                 <= data_nxt;
			rdata_r                <= rdata_nxt;
			ce_n_o                 <= ce_n_nxt;
			token_space_select_n_o <= sem_n_nxt;
			rw_n_o                 <= rw_n_nxt;
			oe_n_o                 <= oe_n_nxt;
			data_oe_o              <= doe_nxt;
			done_r                 <= done_nxt;
			blk_r                  <= blk_nxt;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_idle_standby: assert property (@(posedge clock_i) disable iff (rst_i)
		st_r == dpm_pkg::S_IDLE |-> ce_n_o && token_space_select_n_o)
		else $error("port not in standby while idle");
	a_write_after_settle: assert property (@(posedge clock_i) disable iff (rst_i)
		$fell(rw_n_o) && !ce_n_o |-> !$past(ce_n_o) && !$past(ce_n_o, 2))
		else $error("write pulse began before busy settled");
	a_busy_no_write: assert property (@(posedge clock_i) disable iff (rst_i)
		$fell(rw_n_o) && !ce_n_o |-> $past(busy_n_i))
		else $error("write pulse issued against busy");
	a_token_never_blocked: assert property (@(posedge clock_i) disable iff (rst_i)
		!token_space_select_n_o |=> !blk_r)
		else $error("token access reported blocked");
	a_token_read_release: assert property (@(posedge clock_i) disable iff (rst_i)
		!token_space_select_n_o && !oe_n_o |-> ##[1:4] token_space_select_n_o && oe_n_o)
		else $error("token read select not released");
	a_mem_token_apart: assert property (@(posedge clock_i) disable iff (rst_i)
		!(!ce_n_o && !token_space_select_n_o))
		else $error("memory and token space selected together");
endmodule
`default_nettype wire

// File: hdl/dpm_pkg.sv
`default_nettype none
package dpm_pkg;
	// ----------------------------------------------------------------
	// widths and fixed addresses of the far device
	// ----------------------------------------------------------------
	localparam int AW = 15;
	localparam int DW = 16;
	localparam logic [AW-1:0] MBOX_LEFT_ADDR  = 15'h7FFE;
	localparam logic [AW-1:0] MBOX_RIGHT_ADDR = 15'h7FFF;
	localparam logic [AW-1:0] SEM_ADDR_MASK   = 15'h0007;

	// ----------------------------------------------------------------
	// pin timing, printed figure and derived cycle counts at 125 MHz
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 8;
	localparam int T_SETTLE_NS     = 15;
	localparam int T_STROBE_NS     = 15;
	localparam int SETTLE_CYC_I    = (T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC_I    = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] SETTLE_CYC = 3'(SETTLE_CYC_I);
	localparam logic [2:0] STROBE_CYC = 3'(STROBE_CYC_I);
	localparam logic [2:0] CNT_ONE    = 3'h1;

	// ----------------------------------------------------------------
	// register map of the controller, word index on the port
	// ----------------------------------------------------------------
	localparam logic [2:0] REG_CTRL   = 3'h0;
	localparam logic [2:0] REG_CMD    = 3'h1;
	localparam logic [2:0] REG_ADDR   = 3'h2;
	localparam logic [2:0] REG_WDATA  = 3'h3;
	localparam logic [2:0] REG_RDATA  = 3'h4;
	localparam logic [2:0] REG_STATUS = 3'h5;

	localparam int CTRL_MBOX_EN  = 0;
	localparam int ST_ACTIVE     = 0;
	localparam int ST_DONE       = 1;
	localparam int ST_BLOCKED    = 2;
	localparam int ST_MBOX       = 3;
	localparam logic [DW-1:0] ZERO_W = 16'h0000;

	// ----------------------------------------------------------------
	// commands and pin cycle kinds
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_MEM_RD = 3'h0;
	localparam logic [2:0] CMD_MEM_WR = 3'h1;
	localparam logic [2:0] CMD_SEM_RD = 3'h2;
	localparam logic [2:0] CMD_SEM_WR = 3'h3;
	localparam logic [2:0] CMD_NOTIFY = 3'h4;
	localparam logic [2:0] CMD_ACK    = 3'h5;

	typedef enum logic [1:0] {K_MEM_RD, K_MEM_WR, K_SEM_RD, K_SEM_WR} dpm_kind_e;
	typedef enum {S_IDLE, S_SETUP, S_STROBE, S_RECOVER} dpm_state_e;
endpackage
`default_nettype wire

// File: testbench/dpm_dev_model.sv
`default_nettype none
module dpm_dev_model
(
	// clock of the sampling host
	input  wire logic                   clock_i,
	// port pins driven by the host
	input  wire logic [dpm_pkg::AW-1:0] addr_i,
	input  wire logic                   ce_n_i,
	input  wire logic                   token_space_select_n_i,
	input  wire logic                   rw_n_i,
	input  wire logic                   oe_n_i,
	input  wire logic [dpm_pkg::DW-1:0] data_i,
	// answers to the host
	output logic      [dpm_pkg::DW-1:0] data_o,
	output logic                        busy_n_o,
	output logic                        mailbox_flag_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// storage, token flags and the far processor's view
	// ----------------------------------------------------------------
	logic [dpm_pkg::DW-1:0] mem [0:32767];
	logic [7:0]             host_own = 8'h00;
	logic [7:0]             peer_own = 8'h00;
	logic                   peer_flag_n = 1'b1;
	logic                   peer_ce = 1'b0;
	logic [dpm_pkg::AW-1:0] peer_addr = 15'h0000;
	logic [dpm_pkg::DW-1:0] last_q = 16'h0000;
	logic [dpm_pkg::DW-1:0] tok_latch = 16'h0000;
	logic                   tok_latched = 1'b0;
	logic [2:0]             tix;
	initial mailbox_flag_n_o = 1'b1;
	assign tix = addr_i[2:0];
	// far port always arrived first, so only this side ever sees busy
	assign busy_n_o = !(peer_ce && !ce_n_i && addr_i == peer_addr);
	// ----------------------------------------------------------------
	// read path; a released bus inverts every cycle, so the last data shows again every second cycle
	// ----------------------------------------------------------------
	always_comb
	begin
		if (ce_n_i && !token_space_select_n_i && !oe_n_i)
			data_o = tok_latched ? tok_latch : {16{~host_own[tix]}};
		else if (!ce_n_i && !oe_n_i && rw_n_i)
			data_o = mem[addr_i];
		else
			data_o = ~last_q;
	end
	always @(posedge clock_i)
	begin
		last_q <= data_o;
		if (!ce_n_i && !rw_n_i && busy_n_o)
		begin
			mem[addr_i] <= data_i;
			if (addr_i == dpm_pkg::MBOX_RIGHT_ADDR)
				peer_flag_n <= 1'b0;
		end
		if (!ce_n_i && !oe_n_i && addr_i == dpm_pkg::MBOX_LEFT_ADDR)
			mailbox_flag_n_o <= 1'b1;
		if (ce_n_i && !token_space_select_n_i && !rw_n_i)
		begin
			if (!data_i[0] && !peer_own[tix])
				host_own[tix] <= 1'b1;
			if (data_i[0])
				host_own[tix] <= 1'b0;
		end
		if (!token_space_select_n_i && !oe_n_i)
		begin
			if (!tok_latched)
				tok_latch <= {16{~host_own[tix]}};
			tok_latched <= 1'b1;
		end
		else
			tok_latched <= 1'b0;
	end
	// ----------------------------------------------------------------
	// actions of the far processor, called by the bench between edges
	// ----------------------------------------------------------------
	task automatic peer_write(input logic [14:0] a, input logic [15:0] d);
		mem[a] = d;
		if (a == dpm_pkg::MBOX_LEFT_ADDR)
			mailbox_flag_n_o <= 1'b0;
	endtask
	task automatic peer_read(input logic [14:0] a, output logic [15:0] d);
		d = mem[a];
		if (a == dpm_pkg::MBOX_RIGHT_ADDR)
			peer_flag_n = 1'b1;
	endtask
	task automatic peer_token(input logic [2:0] i, input logic v);
		if (!v && !host_own[i])
			peer_own[i] = 1'b1;
		if (v)
			peer_own[i] = 1'b0;
	endtask
	task automatic peer_hold(input logic on, input logic [14:0] a);
		peer_ce = on;
		peer_addr = a;
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_dpm_host.sv
`default_nettype none
module tb_dpm_host;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [2:0]  reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [14:0] pin_addr;
	logic        ce_n;
	logic        token_space_select_n;
	logic        rw_n;
	logic        oe_n;
	logic        data_oe;
	logic [15:0] host_data;
	logic [15:0] dev_data;
	logic [15:0] bus_data;
	logic        busy_n;
	logic        mbox_flag_n;
	int          num_errors = 0;
	int          tests_run = 0;
	always #4 clock_i = ~clock_i;
	// write data reaches the device only while the host enables its drivers
	assign bus_data = data_oe ? host_data : 16'h0000;
	dpm_host #(.PORT_IS_LEFT(1'b1)) i_dut (.clock_i(clock_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .addr_o(pin_addr), .ce_n_o(ce_n),
		.token_space_select_n_o(token_space_select_n), .rw_n_o(rw_n), .oe_n_o(oe_n),
		.data_oe_o(data_oe), .data_o(host_data), .data_i(dev_data), .busy_n_i(busy_n),
		.mailbox_flag_n_i(mbox_flag_n));
	dpm_dev_model i_dev (.clock_i(clock_i), .addr_i(pin_addr), .ce_n_i(ce_n),
		.token_space_select_n_i(token_space_select_n), .rw_n_i(rw_n), .oe_n_i(oe_n),
		.data_i(bus_data), .data_o(dev_data), .busy_n_o(busy_n), .mailbox_flag_n_o(mbox_flag_n));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// strobe is lowered at the sampling edge, so the next call raises it an edge later
	task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock_i);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
		@(posedge clock_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock_i);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic run_cmd(input logic [2:0] c, input logic [14:0] a, input logic [15:0] d,
		input logic [15:0] exp_st, output logic [15:0] rd);
		int          n;
		logic [15:0] st;
		n = 0;
		st = 16'h0000;
		reg_write(dpm_pkg::REG_ADDR, {1'b0, a});
		reg_write(dpm_pkg::REG_WDATA, d);
		reg_write(dpm_pkg::REG_CMD, {13'h0000, c});
		while (st[dpm_pkg::ST_DONE] !== 1'b1 && n < 40)
		begin
			reg_read(dpm_pkg::REG_STATUS, st);
			n++;
		end
		chk(st & 16'h0007, exp_st);
		if (st[dpm_pkg::ST_DONE] !== 1'b1)
		begin
			num_errors++;
			close_out();
		end
		reg_write(dpm_pkg::REG_STATUS, 16'h0006);
		reg_read(dpm_pkg::REG_RDATA, rd);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [15:0] st;
		chk({11'h000, ce_n, token_space_select_n, rw_n, oe_n, data_oe}, 16'h001E);
		reg_read(dpm_pkg::REG_STATUS, st);
		chk(st, 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_memory();
		logic [15:0] rd;
		run_cmd(dpm_pkg::CMD_MEM_WR, 15'h0123, 16'hA5C3, 16'h0002, rd);
		chk(i_dev.mem[15'h0123], 16'hA5C3);
		run_cmd(dpm_pkg::CMD_MEM_RD, 15'h0123, 16'h0000, 16'h0002, rd);
		chk(rd, 16'hA5C3);
		run_cmd(dpm_pkg::CMD_MEM_WR, dpm_pkg::MBOX_LEFT_ADDR, 16'h5AF0, 16'h0002, rd);
		run_cmd(dpm_pkg::CMD_MEM_RD, dpm_pkg::MBOX_LEFT_ADDR, 16'h0000, 16'h0002, rd);
		chk(rd, 16'h5AF0);
		reg_read(dpm_pkg::REG_ADDR, rd);
		chk(rd, {1'b0, dpm_pkg::MBOX_LEFT_ADDR});
		$display("test memory done");
	endtask
	task automatic t_mailbox();
		logic [15:0] st;
		logic [15:0] rd;
		reg_write(dpm_pkg::REG_CTRL, 16'h0001);
		i_dev.peer_write(dpm_pkg::MBOX_LEFT_ADDR, 16'h0F1E);
		reg_read(dpm_pkg::REG_CTRL, st);
		chk(st, 16'h0001);
		reg_read(dpm_pkg::REG_STATUS, st);
		chk(st & 16'h0008, 16'h0008);
		reg_write(dpm_pkg::REG_CTRL, 16'h0000);
		reg_read(dpm_pkg::REG_STATUS, st);
		chk(st & 16'h0008, 16'h0000);
		reg_write(dpm_pkg::REG_CTRL, 16'h0001);
		run_cmd(dpm_pkg::CMD_ACK, 15'h0000, 16'h0000, 16'h0002, rd);
		chk(rd, 16'h0F1E);
		reg_read(dpm_pkg::REG_STATUS, st);
		chk(st & 16'h0008, 16'h0000);
		run_cmd(dpm_pkg::CMD_NOTIFY, 15'h0000, 16'h3C69, 16'h0002, rd);
		chk({15'h0000, i_dev.peer_flag_n}, 16'h0000);
		i_dev.peer_read(dpm_pkg::MBOX_RIGHT_ADDR, rd);
		chk(rd, 16'h3C69);
		$display("test mailbox done");
	endtask
	task automatic t_busy();
		logic [15:0] rd;
		i_dev.peer_write(15'h0200, 16'h7777);
		i_dev.peer_hold(1'b1, 15'h0200);
		run_cmd(dpm_pkg::CMD_MEM_WR, 15'h0200, 16'h1111, 16'h0006, rd);
		chk(i_dev.mem[15'h0200], 16'h7777);
		run_cmd(dpm_pkg::CMD_MEM_RD, 15'h0200, 16'h0000, 16'h0002, rd);
		chk(rd, 16'h7777);
		run_cmd(dpm_pkg::CMD_SEM_WR, 15'h0200, 16'h0001, 16'h0002, rd);
		i_dev.peer_hold(1'b0, 15'h0000);
		run_cmd(dpm_pkg::CMD_MEM_WR, 15'h0200, 16'h1111, 16'h0002, rd);
		chk(i_dev.mem[15'h0200], 16'h1111);
		$display("test busy done");
	endtask
	task automatic t_token();
		logic [15:0] rd;
		for (int i = 0; i < 8; i++)
		begin
			if (i == 5)
				i_dev.peer_token(3'(i), 1'b0);
			run_cmd(dpm_pkg::CMD_SEM_WR, 15'h7FF8 | 15'(i), 16'hFFFE, 16'h0002, rd);
			run_cmd(dpm_pkg::CMD_SEM_RD, 15'h0010 | 15'(i), 16'h0000, 16'h0002, rd);
			chk(rd, (i == 5) ? 16'hFFFF : 16'h0000);
			run_cmd(dpm_pkg::CMD_SEM_WR, 15'(i), 16'h0001, 16'h0002, rd);
			run_cmd(dpm_pkg::CMD_SEM_RD, 15'(i), 16'h0000, 16'h0002, rd);
			chk(rd, 16'hFFFF);
		end
		$display("test token done");
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		#1 t_reset();
		t_memory();
		t_mailbox();
		t_busy();
		t_token();
		close_out();
	end
endmodule
`default_nettype wire
